//--- hw/mdv_unit.sv
// Purpose: Multiply/divide unit beside the integer pipeline.
// Assumes: Requests are synchronous to MCLK; ISSUE_READY low means the pipeline must hold.
// Notes: Holds the high and low result halves; general register multiplies return on GPR_OUT.
`timescale 1ns/10ps
`include "mdv_regs.svh"

module mdv_unit (
    input wire logic MCLK,
    input wire logic RESET,
    input mdv_pkg::mdv_req_type ISSUE,
    output logic ISSUE_READY,
    output logic [31:0] RESULT_HIGH,
    output logic [31:0] RESULT_LOW,
    output mdv_pkg::mdv_gpr_type GPR_OUT,
    output logic DIV_BUSY
);
    import mdv_pkg::*;

    mdv_state_type st_ff;
    mdv_state_type nxt_st;
    logic accept;
    logic sgn;
    logic is_div;
    logic narrow;
    logic p2_sgn;
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] mcand;
    logic [16:0] mplier;
    logic [49:0] booth_p;
    logic [63:0] prod_ext;
    logic [63:0] full;
    logic [63:0] hilo;
    logic [31:0] a_abs;
    logic [31:0] b_abs;
    logic [5:0] skip;
    logic [5:0] lat;
    logic [32:0] trial;
    logic [31:0] rem_s;
    logic [31:0] quo_s;

    // ****************************************
    // Request decode and width detection.
    // ****************************************
    assign a = ISSUE.first_source_operand;
    assign b = ISSUE.second_source_operand;
    assign sgn = ISSUE.op inside {signed_multiply_op, signed_mul_accumulate_op, signed_mul_subtract_op,
                                  gpr_multiply_op, signed_divide_op};
    assign is_div = ISSUE.op inside {signed_divide_op, unsigned_divide_op};
    assign narrow = sgn ? (&b[31:15] | ~|b[31:15]) : ~|b[31:16];
    assign p2_sgn = st_ff.pass2_op inside {signed_multiply_op, signed_mul_accumulate_op,
                                           signed_mul_subtract_op, gpr_multiply_op};

    // Busy second pass holds the integer pipeline; a running divide holds all but a divide or register multiply in its last cycle.
    always_comb begin
        ISSUE_READY = 1'b1;
        if (st_ff.pass2) begin
            ISSUE_READY = 1'b0;
        end else if (st_ff.div_act) begin
            ISSUE_READY = (st_ff.div_lat == 6'h01) && (is_div || ISSUE.op == gpr_multiply_op);
        end
    end
    assign accept = ISSUE.valid && ISSUE_READY;

    // ****************************************
    // Multiplier array and its operand select.
    // ****************************************
    always_comb begin
        if (st_ff.pass2) begin
            mcand = {p2_sgn & st_ff.opa[31], st_ff.opa};
            mplier = {p2_sgn & st_ff.opb[31], st_ff.opb[31:16]};
        end else begin
            mcand = {sgn & a[31], a};
            mplier = {narrow & sgn & b[15], b[15:0]};
        end
    end

    mdv_booth u_booth (
        .mcand(mcand),
        .mplier(mplier),
        .product(booth_p)
    );

    assign prod_ext = {{14{booth_p[49]}}, booth_p};
    assign full = st_ff.pass2 ? st_ff.part + (prod_ext << 16) : prod_ext;
    assign hilo = {st_ff.result_high_half, st_ff.result_low_half};

    // ****************************************
    // Divide setup and one iteration step.
    // ****************************************
    always_comb begin
        a_abs = (sgn & a[31]) ? -a : a;
        b_abs = (sgn & b[31]) ? -b : b;
        if (sgn ? (&a[31:7] | ~|a[31:7]) : ~|a[31:8]) begin
            skip = `MDV_SKIP_8;
            lat = `MDV_DIV_LAT_8;
        end else if (sgn ? (&a[31:15] | ~|a[31:15]) : ~|a[31:16]) begin
            skip = `MDV_SKIP_16;
            lat = `MDV_DIV_LAT_16;
        end else if (sgn ? (&a[31:23] | ~|a[31:23]) : ~|a[31:24]) begin
            skip = `MDV_SKIP_24;
            lat = `MDV_DIV_LAT_24;
        end else begin
            skip = 6'h00;
            lat = `MDV_DIV_LAT_32;
        end
        trial = {st_ff.rem, st_ff.quo[31]};
        rem_s = st_ff.rem;
        quo_s = st_ff.quo;
        if (st_ff.div_iter != 6'h00) begin
            if (trial >= {1'b0, st_ff.dvsr}) begin
                rem_s = trial[31:0] - st_ff.dvsr;
                quo_s = {st_ff.quo[30:0], 1'b1};
            end else begin
                rem_s = trial[31:0];
                quo_s = {st_ff.quo[30:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pass2 = 1'b0;
        nxt_st.stage_v = 1'b0;
        nxt_st.gpr_v = st_ff.stage_v;
        if (st_ff.stage_v) begin
            nxt_st.gpr_d = st_ff.stage_d;
        end
        if (st_ff.pass2) begin
            if (st_ff.pass2_op == gpr_multiply_op) begin
                nxt_st.stage_v = 1'b1;
                nxt_st.stage_d = full[31:0];
            end else if (st_ff.pass2_op inside {signed_mul_subtract_op, unsigned_mul_subtract_op}) begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = hilo - full;
            end else if (st_ff.pass2_op inside {signed_mul_accumulate_op, unsigned_mul_accumulate_op}) begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = hilo + full;
            end else begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = full;
            end
        end
        if (st_ff.div_act) begin
            nxt_st.rem = rem_s;
            nxt_st.quo = quo_s;
            nxt_st.div_iter = (st_ff.div_iter != 6'h00) ? st_ff.div_iter - 6'h01 : 6'h00;
            nxt_st.div_lat = st_ff.div_lat - 6'h01;
            if (st_ff.div_lat == 6'h01) begin
                nxt_st.div_act = 1'b0;
                nxt_st.result_low_half = st_ff.q_neg ? -quo_s : quo_s;
                nxt_st.result_high_half = st_ff.r_neg ? -rem_s : rem_s;
            end
        end
        if (accept) begin
            if (is_div) begin
                nxt_st.div_act = 1'b1;
                nxt_st.div_lat = lat - 6'h01;
                nxt_st.div_iter = `MDV_DIV_BITS - skip;
                nxt_st.quo = a_abs << skip;
                nxt_st.rem = '0;
                nxt_st.dvsr = b_abs;
                nxt_st.q_neg = sgn & (a[31] ^ b[31]);
                nxt_st.r_neg = sgn & a[31];
            end else if (!narrow) begin
                nxt_st.pass2 = 1'b1;
                nxt_st.pass2_op = ISSUE.op;
                nxt_st.opa = a;
                nxt_st.opb = b;
                nxt_st.part = prod_ext;
            end else if (ISSUE.op == gpr_multiply_op) begin
                nxt_st.stage_v = 1'b1;
                nxt_st.stage_d = prod_ext[31:0];
            end else if (ISSUE.op inside {signed_mul_subtract_op, unsigned_mul_subtract_op}) begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = hilo - prod_ext;
            end else if (ISSUE.op inside {signed_mul_accumulate_op, unsigned_mul_accumulate_op}) begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = hilo + prod_ext;
            end else begin
                {nxt_st.result_high_half, nxt_st.result_low_half} = prod_ext;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RESULT_HIGH = st_ff.result_high_half;
    assign RESULT_LOW = st_ff.result_low_half;
    assign GPR_OUT = '{valid: st_ff.gpr_v, data: st_ff.gpr_d};
    assign DIV_BUSY = st_ff.div_act;

    // ****************************************
    // Assertions.
    // ****************************************
    logic [63:0] ref_prod;
    logic [31:0] ref_low;
    logic [31:0] ref_q;
    logic [31:0] ref_r;
    logic [63:0] out_pair;
    assign ref_prod = {{32{sgn & a[31]}}, a} * {{32{sgn & b[31]}}, b};
    assign ref_low = ref_prod[31:0];
    assign ref_q = (b != 32'h0000_0000) ? a / b : 32'h0000_0000;
    assign ref_r = (b != 32'h0000_0000) ? a % b : 32'h0000_0000;
    assign out_pair = {RESULT_HIGH, RESULT_LOW};

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    property p_div_stall;
        st_ff.div_act && st_ff.div_lat > 6'h01 |-> !ISSUE_READY;
    endproperty
    a_div_stall: assert property (p_div_stall) else $error("Request taken during a divide.");

    property p_pass2_stall;
        accept && !is_div && !narrow |=> !ISSUE_READY ##1 (ISSUE_READY || st_ff.div_act);
    endproperty
    a_pass2_stall: assert property (p_pass2_stall) else $error("Wide multiply repeat rate wrong.");

    property p_narrow_rate;
        accept && !is_div && narrow && !st_ff.div_act |=> ISSUE_READY;
    endproperty
    a_narrow_rate: assert property (p_narrow_rate) else $error("Narrow multiply blocked the next.");

    property p_mul16;
        accept && ISSUE.op inside {signed_multiply_op, unsigned_multiply_op} && narrow |=> out_pair == $past(ref_prod);
    endproperty
    a_mul16: assert property (p_mul16) else $error("Narrow multiply result wrong.");

    property p_mul32;
        accept && ISSUE.op inside {signed_multiply_op, unsigned_multiply_op} && !narrow
            |-> ##2 out_pair == $past(ref_prod, 2);
    endproperty
    a_mul32: assert property (p_mul32) else $error("Wide multiply result wrong.");

    property p_macc;
        accept && ISSUE.op == signed_mul_accumulate_op && narrow
            |=> out_pair == $past(hilo) + $past(ref_prod);
    endproperty
    a_macc: assert property (p_macc) else $error("Accumulate result wrong.");

    property p_gpr16;
        accept && ISSUE.op == gpr_multiply_op && narrow |-> ##2 GPR_OUT.valid && GPR_OUT.data == $past(ref_low, 2);
    endproperty
    a_gpr16: assert property (p_gpr16) else $error("Register multiply latency wrong.");

    property p_div8;
        accept && ISSUE.op == unsigned_divide_op && a[31:8] == 24'h00_0000 && b != 32'h0000_0000
            |-> ##12 RESULT_LOW == $past(ref_q, 12) && RESULT_HIGH == $past(ref_r, 12);
    endproperty
    a_div8: assert property (p_div8) else $error("Short divide result or latency wrong.");

    property p_div32;
        accept && ISSUE.op == unsigned_divide_op && a[31:24] != 8'h00 && b != 32'h0000_0000
            |-> ##33 RESULT_LOW == $past(ref_q, 33) && RESULT_HIGH == $past(ref_r, 33);
    endproperty
    a_div32: assert property (p_div32) else $error("Full divide result or latency wrong.");

    property p_div_skip;
        accept && ISSUE.op == unsigned_divide_op && a[31:8] == 24'h00_0000 |=> st_ff.div_iter == 6'h09;
    endproperty
    a_div_skip: assert property (p_div_skip) else $error("Divide skip count wrong.");

    c_back_to_back: cover property (accept && narrow && !is_div ##1 accept && narrow && !is_div);
    c_wide_stall: cover property (accept && !narrow && !is_div ##1 ISSUE.valid && !ISSUE_READY);
    c_div_full: cover property (accept && is_div && lat == `MDV_DIV_LAT_32);

endmodule // mdv_unit

//--- common/mdv_regs.svh
// Purpose: Timing counts and sizes of the multiply/divide unit.
// Assumes: Counts are in MCLK cycles.
// Notes: Definitions only.
`ifndef MDV_REGS_SVH
`define MDV_REGS_SVH

// Divide iterations skipped for an 8, 16 or 24 bit dividend (23, 15, 7).
`define MDV_SKIP_8 6'h17
`define MDV_SKIP_16 6'h0f
`define MDV_SKIP_24 6'h07
// Quotient bits of a full divide (32).
`define MDV_DIV_BITS 6'h20
// Divide latency per dividend width (12, 19, 26, 33); repeat rate is one less.
`define MDV_DIV_LAT_8 6'h0c
`define MDV_DIV_LAT_16 6'h13
`define MDV_DIV_LAT_24 6'h1a
`define MDV_DIV_LAT_32 6'h21
// Booth digits of one 17-bit multiplier slice.
`define MDV_BOOTH_DIGITS 9

`endif

//--- common/mdv_pkg.sv
// Purpose: Types shared by the multiply/divide unit.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes: All state of the top module is one packed struct.
package mdv_pkg;

    typedef enum logic [3:0] {
        signed_multiply_op,
        unsigned_multiply_op,
        signed_mul_accumulate_op,
        unsigned_mul_accumulate_op,
        signed_mul_subtract_op,
        unsigned_mul_subtract_op,
        gpr_multiply_op,
        signed_divide_op,
        unsigned_divide_op
    } mdv_op_type;

    typedef struct packed {
        logic valid;
        mdv_op_type op;
        logic [31:0] first_source_operand;
        logic [31:0] second_source_operand;
    } mdv_req_type;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } mdv_gpr_type;

    typedef struct packed {
        logic [31:0] result_high_half;
        logic [31:0] result_low_half;
        logic pass2;
        mdv_op_type pass2_op;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [63:0] part;
        logic div_act;
        logic [5:0] div_lat;
        logic [5:0] div_iter;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] dvsr;
        logic q_neg;
        logic r_neg;
        logic stage_v;
        logic [31:0] stage_d;
        logic gpr_v;
        logic [31:0] gpr_d;
    } mdv_state_type;

endpackage

//--- hw/mdv_booth.sv
// Purpose: Radix-4 Booth recoded 33x17 signed multiplier array.
// Assumes: Operands arrive already sign or zero extended.
// Notes: Purely combinational; one pass of the unit.
`timescale 1ns/10ps
`include "mdv_regs.svh"

module mdv_booth (
    input wire logic [32:0] mcand,
    input wire logic [16:0] mplier,
    output logic [49:0] product
);
    import mdv_pkg::*;

    logic [18:0] mext;
    logic [49:0] aext;
    logic [`MDV_BOOTH_DIGITS-1:0][49:0] pp;

    assign mext = {mplier[16], mplier, 1'b0};
    assign aext = {{17{mcand[32]}}, mcand};

    // ****************************************
    // Partial products, one per Booth digit.
    // ****************************************
    for (genvar g = 0; g < `MDV_BOOTH_DIGITS; g++) begin : g_pp
        logic [49:0] sel;
        always_comb begin
            case (mext[2*g+2 -: 3])
                3'h1, 3'h2: sel = aext;
                3'h3: sel = aext << 1;
                3'h4: sel = -(aext << 1);
                3'h5, 3'h6: sel = -aext;
                default: sel = '0;
            endcase
        end
        assign pp[g] = sel << (2 * g);
    end

    // ****************************************
    // Sum of the partial products.
    // ****************************************
    always_comb begin
        product = '0;
        for (int i = 0; i < `MDV_BOOTH_DIGITS; i++) begin
            product = product + pp[i];
        end
    end

endmodule // mdv_booth

//--- dv/mdv_issuer.sv
// Purpose: Integer pipeline model that issues requests to the unit.
// Assumes: Requests change on the falling edge of MCLK.
// Notes: The bench fills q; n_taken counts requests taken.
`timescale 1ns/10ps

module mdv_issuer (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic ISSUE_READY,
    output mdv_pkg::mdv_req_type ISSUE
);
    import mdv_pkg::*;
    mdv_req_type q[$];
    int n_taken = 0;
    logic took = 1'b0;
    initial ISSUE = '0;
    // A stalled request stands unchanged; an idle bus shows inverted operands.
    always @(negedge MCLK) begin
        if (!ISSUE.valid || took) begin
            if (q.size() > 0) begin
                ISSUE <= q.pop_front();
            end else begin
                ISSUE <= '{1'b0, signed_multiply_op, ~ISSUE.first_source_operand, ~ISSUE.second_source_operand};
            end
        end
    end
    always @(posedge MCLK) begin
        took <= ISSUE.valid && ISSUE_READY && !RESET;
        if (ISSUE.valid && ISSUE_READY && !RESET) begin
            n_taken <= n_taken + 1;
        end
    end
endmodule // mdv_issuer

//--- dv/mdv_unit_test.sv
// Purpose: Self-checking bench of the multiply/divide unit.
// Assumes: Inputs move on the falling edge of MCLK.
// Notes: Expected values come from plain arithmetic here.
`timescale 1ns/10ps

module mdv_unit_test;
    import mdv_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    mdv_req_type issue;
    logic issue_ready;
    logic [31:0] res_high;
    logic [31:0] res_low;
    mdv_gpr_type gpr;
    logic div_busy;
    logic [63:0] acc = 64'h0;
    int n_mismatch = 0;
    int n_compared = 0;

    mdv_unit uut (.MCLK(mclk), .RESET(reset), .ISSUE(issue), .ISSUE_READY(issue_ready),
        .RESULT_HIGH(res_high), .RESULT_LOW(res_low), .GPR_OUT(gpr), .DIV_BUSY(div_busy));
    mdv_issuer drv (.MCLK(mclk), .RESET(reset), .ISSUE_READY(issue_ready), .ISSUE(issue));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic uns(input mdv_op_type op);
        return op inside {unsigned_multiply_op, unsigned_mul_accumulate_op, unsigned_mul_subtract_op};
    endfunction

    function automatic logic [63:0] prod(input mdv_op_type op, input logic [31:0] a, input logic [31:0] b);
        if (uns(op)) begin
            return {32'h0000_0000, a} * {32'h0000_0000, b};
        end
        return {{32{a[31]}}, a} * {{32{b[31]}}, b};
    endfunction

    task automatic wait_take(input int k);
        int n = 0;
        while (drv.n_taken < k && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(64'(drv.n_taken >= k), 64'h1);
    endtask

    task automatic push(input mdv_op_type op, input logic [31:0] a, input logic [31:0] b);
        drv.q.push_back('{1'b1, op, a, b});
    endtask

    task automatic mul_one(input mdv_op_type op, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] p;
        int lat;
        int k;
        p = prod(op, a, b);
        lat = (uns(op) ? ~|b[31:16] : (~|b[31:15] || &b[31:15])) ? 1 : 2;
        k = drv.n_taken + 1;
        if (op == gpr_multiply_op) begin
            lat++;
        end else if (op inside {signed_mul_accumulate_op, unsigned_mul_accumulate_op}) begin
            acc = acc + p;
        end else if (op inside {signed_mul_subtract_op, unsigned_mul_subtract_op}) begin
            acc = acc - p;
        end else begin
            acc = p;
        end
        push(op, a, b);
        wait_take(k);
        if (lat > 1) begin
            repeat (lat - 2) @(negedge mclk);
            check(64'(gpr.valid), 64'h0);
            check(64'({res_high, res_low} === acc), 64'(op == gpr_multiply_op));
            @(negedge mclk);
        end
        if (op == gpr_multiply_op) begin
            check({31'h0, gpr.valid, gpr.data}, {32'h0000_0001, p[31:0]});
            @(negedge mclk);
            check(64'(gpr.valid), 64'h0);
        end else begin
            check({res_high, res_low}, acc);
        end
    endtask

    task automatic t_ops;
        logic [31:0] bs[3] = '{32'hFFFF_8001, 32'h0001_2345, 32'h0000_7ABC};
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 7; i++) begin
                mul_one(mdv_op_type'(i), 32'h9ABC_DEF0 + j, bs[j]);
            end
        end
    endtask

    task automatic t_b2b;
        int k = drv.n_taken + 1;
        for (int i = 0; i < 3; i++) push(signed_multiply_op, 32'h1234_5678 + i, 32'h0000_7FF0 - i);
        wait_take(k);
        for (int i = 0; i < 3; i++) begin
            check({res_high, res_low}, prod(signed_multiply_op, 32'h1234_5678 + i, 32'h0000_7FF0 - i));
            check(64'(drv.n_taken - k), 64'(i));
            @(negedge mclk);
        end
    endtask

    task automatic t_wide;
        int k = drv.n_taken + 1;
        push(signed_multiply_op, 32'h0000_0003, 32'h1234_5678);
        push(unsigned_multiply_op, 32'h0000_0005, 32'h0002_0000);
        wait_take(k);
        #1;
        check(64'(issue_ready), 64'h0);
        @(negedge mclk);
        check({res_high, res_low}, 64'h0000_0000_369D_0368);
        check(64'(drv.n_taken), 64'(k));
        @(negedge mclk);
        check(64'(drv.n_taken), 64'(k + 1));
        check(64'(issue_ready), 64'h0);
        @(negedge mclk);
        check({res_high, res_low}, 64'h0000_0000_000A_0000);
    endtask

    task automatic t_div;
        mdv_op_type dop[5] = '{signed_divide_op, signed_divide_op, unsigned_divide_op, unsigned_divide_op,
            unsigned_divide_op};
        logic [31:0] da[5] = '{32'hFFFF_FF9C, 32'h0000_7530, 32'h0012_3456, 32'h8765_4321, 32'h0000_00C8};
        logic [31:0] db[5] = '{32'h0000_0007, 32'hFFFF_FF85, 32'h0000_03E8, 32'h0000_1234, 32'h0000_000D};
        int dl[5] = '{12, 19, 26, 33, 12};
        logic [31:0] q;
        logic [31:0] r;
        int k;
        for (int i = 0; i < 5; i++) begin
            if (i < 2) begin
                q = $signed(da[i]) / $signed(db[i]);
                r = $signed(da[i]) % $signed(db[i]);
            end else begin
                q = da[i] / db[i];
                r = da[i] % db[i];
            end
            k = drv.n_taken + 1;
            push(dop[i], da[i], db[i]);
            push(dop[i], da[i], db[i]);
            push(signed_multiply_op, 32'h0000_0003, 32'h0000_0005);
            wait_take(k);
            repeat (dl[i] - 2) @(negedge mclk);
            check(64'(div_busy), 64'h1);
            check(64'({res_high, res_low} === {r, q}), 64'h0);
            check(64'(drv.n_taken), 64'(k));
            @(negedge mclk);
            check({res_high, res_low}, {r, q});
            check(64'(drv.n_taken), 64'(k + 1));
            repeat (dl[i] - 1) @(negedge mclk);
            check(64'(div_busy), 64'h0);
            check(64'(drv.n_taken), 64'(k + 1));
            @(negedge mclk);
            check(64'(drv.n_taken), 64'(k + 2));
            check({res_high, res_low}, 64'h0000_0000_0000_000F);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        check({res_high, res_low}, 64'h0);
        check({29'h0, issue_ready, div_busy, gpr}, 64'h0000_0004_0000_0000);
        t_ops();
        t_b2b();
        t_wide();
        t_div();
        print_verdict();
    end

    initial begin
        #40000;
        n_mismatch++;
        print_verdict();
    end
endmodule // mdv_unit_test
